//--- rtl/pxs_pkg.sv
// Constants shared by the parallel pixel serializer and its word buffer.
package pxs_pkg;

	// ------------------------------------------------------------
	// Word and lane geometry.
	// ------------------------------------------------------------
	localparam int PXS_PIXEL_BITS  = 28;
	localparam int PXS_LANES       = 4;
	localparam int PXS_SLICE_BITS  = 7;
	localparam int PXS_FIFO_DEPTH  = 8;

	// Bit slot counter: slots 0 to 6 form one pixel period.
	localparam logic [2:0] PXS_SLOT_FIRST = 3'h0;
	localparam logic [2:0] PXS_SLOT_LAST  = 3'h6;
	// Forwarded clock is high in slots 0 to 3 and low in slots 4 to 6.
	localparam logic [2:0] PXS_CLK_HIGH_SLOTS = 3'h4;

	// ------------------------------------------------------------
	// Timing figures.
	// ------------------------------------------------------------
	localparam int PXS_REF_CLK_HZ      = 20000000;
	localparam int PXS_PIXEL_MIN_MHZ   = 10;
	localparam int PXS_PIXEL_MAX_MHZ   = 85;
	localparam int PXS_SYNC_STAGES     = 2;

	// ------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------
	localparam logic [27:0] PXS_WORD_RESET = 28'h0000000;
	localparam logic [6:0]  PXS_SLICE_RESET = 7'h00;

	// Handshake state on the reference clock side.
	typedef enum logic [0:0] {
		PXS_HS_IDLE,
		PXS_HS_WAIT
	} pxs_hs_state_t;

	// Serializer state on the bit clock side.
	typedef enum logic [0:0] {
		PXS_LNK_OFF,
		PXS_LNK_RUN
	} pxs_lnk_state_t;

endpackage

//--- rtl/pxs_fifo.sv
// Synchronous word buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pxs_fifo
	import pxs_pkg::*;
#(
	parameter int WIDTH = PXS_PIXEL_BITS,
	parameter int DEPTH = PXS_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             clear,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             do_write;
	logic             do_read;

	// ------------------------------------------------------------
	// Flags from the pointers; the extra bit tells full from empty.
	// ------------------------------------------------------------
	assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign do_write  = in_valid && in_ready;
	assign do_read   = out_valid && out_ready;

	// Storage is not cleared; the pointers alone decide what is valid.
	always_ff @(posedge clk) begin
		if (do_write) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// Pointers return to empty on clear, which covers reset and shutdown.
	always_ff @(posedge clk) begin
		if (clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_write) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_read) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule

//--- rtl/pxs_serializer.sv
// Pixel capture, word buffer, clock crossing and four-lane serializer.
`timescale 1ns/1ps
module pxs_serializer
	import pxs_pkg::*;
#(
	parameter int PIXEL_BITS = PXS_PIXEL_BITS,
	parameter int LANES      = PXS_LANES,
	parameter int SLICE_BITS = PXS_SLICE_BITS,
	parameter int FIFO_DEPTH = PXS_FIFO_DEPTH
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  serial_bit_clk,
	input  wire logic                  input_pixel_clock,
	input  wire logic                  capture_edge_select,
	input  wire logic [PIXEL_BITS-1:0] pixel_data,
	input  wire logic                  shutdown_clear_n,
	output logic      [LANES-1:0]      lane_pos,
	output logic      [LANES-1:0]      lane_neg,
	output logic                       lane_oe,
	output logic                       forwarded_clock_pos,
	output logic                       forwarded_clock_neg,
	output logic                       forwarded_clock_oe,
	output logic                       pixel_overflow
);

	// ------------------------------------------------------------
	// Reference clock side: pin synchronisers.
	// ------------------------------------------------------------
	logic                  pclk_s1;
	logic                  pclk_s2;
	logic                  pclk_d;
	logic                  sel_s1;
	logic                  sel_s2;
	logic                  shdn_s1;
	logic                  shdn_s2;
	logic [PIXEL_BITS-1:0] data_s1;
	logic [PIXEL_BITS-1:0] data_s2;

	// Every pin passes two flops; data and clock share the same delay so
	// the word seen at the detected edge is the one the source launched.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pclk_s1 <= 1'b0;
			pclk_s2 <= 1'b0;
			sel_s1  <= 1'b0;
			sel_s2  <= 1'b0;
			shdn_s1 <= 1'b0;
			shdn_s2 <= 1'b0;
			data_s1 <= PXS_WORD_RESET;
			data_s2 <= PXS_WORD_RESET;
		end else begin
			pclk_s1 <= input_pixel_clock;
			pclk_s2 <= pclk_s1;
			sel_s1  <= capture_edge_select;
			sel_s2  <= sel_s1;
			shdn_s1 <= shutdown_clear_n;
			shdn_s2 <= shdn_s1;
			data_s1 <= pixel_data;
			data_s2 <= data_s1;
		end
	end

	// ------------------------------------------------------------
	// Capture of the whole pixel word on the selected edge.
	// ------------------------------------------------------------
	logic                  ref_clear;
	logic                  cap_edge;
	logic [PIXEL_BITS-1:0] hold_word;
	logic                  hold_valid;
	logic                  fifo_in_ready;

	assign ref_clear = sys_rst || !shdn_s2;
	// High selects the rising edge, low the falling edge.
	assign cap_edge  = sel_s2 ? (pclk_s2 && !pclk_d) : (!pclk_s2 && pclk_d);

	// Edge history is cleared low with the rest; in rising-edge mode a pixel clock high as shutdown ends reads as an edge.
	always_ff @(posedge ref_clk) begin
		if (ref_clear) begin
			pclk_d <= 1'b0;
		end else begin
			pclk_d <= pclk_s2;
		end
	end

	// All bits load at once into the holding register.
	always_ff @(posedge ref_clk) begin
		if (ref_clear) begin
			hold_word  <= PXS_WORD_RESET;
			hold_valid <= 1'b0;
		end else begin
			hold_valid <= cap_edge;
			if (cap_edge) begin
				hold_word <= data_s2;
			end
		end
	end

	// A pixel that meets a full buffer is dropped; the flag stays until shutdown.
	always_ff @(posedge ref_clk) begin
		if (ref_clear) begin
			pixel_overflow <= 1'b0;
		end else if (hold_valid && !fifo_in_ready) begin
			pixel_overflow <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Word buffer between capture and the crossing.
	// ------------------------------------------------------------
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [PIXEL_BITS-1:0] fifo_out_data;

	pxs_fifo #(
		.WIDTH (PIXEL_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.clear     (ref_clear),
		.in_valid  (hold_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (hold_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// Toggle handshake carrying one word to the bit clock side.
	// ------------------------------------------------------------
	pxs_hs_state_t         hs_state;
	logic [PIXEL_BITS-1:0] xfer_word;
	logic                  xfer_req;
	logic                  ack_s1;
	logic                  ack_s2;
	logic                  xfer_ack;

	// The buffer drains only while no word is in flight, so a slow link
	// stalls it and the buffer really fills.
	assign fifo_out_ready = (hs_state == PXS_HS_IDLE);

	always_ff @(posedge ref_clk) begin
		if (ref_clear) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= xfer_ack;
			ack_s2 <= ack_s1;
		end
	end

	// Word stays stable from the request toggle until the echo returns.
	always_ff @(posedge ref_clk) begin
		if (ref_clear) begin
			hs_state  <= PXS_HS_IDLE;
			xfer_word <= PXS_WORD_RESET;
			xfer_req  <= 1'b0;
		end else begin
			case (hs_state)
				PXS_HS_IDLE: begin
					if (fifo_out_valid) begin
						xfer_word <= fifo_out_data;
						xfer_req  <= !xfer_req;
						hs_state  <= PXS_HS_WAIT;
					end
				end
				PXS_HS_WAIT: begin
					if (ack_s2 == xfer_req) begin
						hs_state <= PXS_HS_IDLE;
					end
				end
				default: begin
					hs_state <= PXS_HS_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bit clock side: reset, shutdown and request synchronisers.
	// ------------------------------------------------------------
	logic rst_b1;
	logic rst_b2;
	logic shdn_b1;
	logic shdn_b2;
	logic req_b1;
	logic req_b2;
	logic lnk_clear;

	// Reset reaches this domain through two flops with no reset of their own,
	// so sys_rst must be high at one link clock edge at least to take hold.
	always_ff @(posedge serial_bit_clk) begin
		rst_b1 <= sys_rst;
		rst_b2 <= rst_b1;
	end

	always_ff @(posedge serial_bit_clk) begin
		if (rst_b2) begin
			shdn_b1 <= 1'b0;
			shdn_b2 <= 1'b0;
			req_b1  <= 1'b0;
			req_b2  <= 1'b0;
		end else begin
			shdn_b1 <= shutdown_clear_n;
			shdn_b2 <= shdn_b1;
			req_b1  <= xfer_req;
			req_b2  <= req_b1;
		end
	end

	assign lnk_clear = rst_b2 || !shdn_b2;

	// ------------------------------------------------------------
	// Slot counter and serializer state.
	// ------------------------------------------------------------
	pxs_lnk_state_t lnk_state;
	logic [2:0]     slot;
	logic           load_now;
	logic           new_word;

	assign load_now = (lnk_state == PXS_LNK_RUN) && (slot == PXS_SLOT_LAST);
	assign new_word = (req_b2 != xfer_ack);

	// Shutdown holds the counter at its last slot; the bit clock itself keeps running.
	always_ff @(posedge serial_bit_clk) begin
		if (lnk_clear) begin
			lnk_state <= PXS_LNK_OFF;
			slot      <= PXS_SLOT_LAST;
		end else begin
			case (lnk_state)
				PXS_LNK_OFF: begin
					lnk_state <= PXS_LNK_RUN;
				end
				PXS_LNK_RUN: begin
					// Seven bit clocks make one pixel period.
					if (slot == PXS_SLOT_LAST) begin
						slot <= PXS_SLOT_FIRST;
					end else begin
						slot <= slot + 3'h1;
					end
				end
				default: begin
					lnk_state <= PXS_LNK_OFF;
				end
			endcase
		end
	end

	// A new word is taken only at the period boundary; with none waiting the
	// period carries zeros rather than repeating stale pixels.
	always_ff @(posedge serial_bit_clk) begin
		if (lnk_clear) begin
			xfer_ack <= 1'b0;
		end else if (load_now && new_word) begin
			xfer_ack <= req_b2;
		end
	end

	// ------------------------------------------------------------
	// Four parallel-load serial-out shift registers.
	// ------------------------------------------------------------
	logic [SLICE_BITS-1:0] shift [LANES];

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			// Lane g carries word bits 7g to 7g+6, lowest bit first.
			always_ff @(posedge serial_bit_clk) begin
				if (lnk_clear) begin
					shift[g]   <= PXS_SLICE_RESET;
					lane_pos[g] <= 1'b0;
					lane_neg[g] <= 1'b0;
				end else if (lnk_state == PXS_LNK_RUN) begin
					// Pair stays at zero until the first period starts with the drivers.
					if (load_now) begin
						shift[g] <= new_word ? xfer_word[g*SLICE_BITS +: SLICE_BITS]
						                     : PXS_SLICE_RESET;
					end else begin
						shift[g] <= {1'b0, shift[g][SLICE_BITS-1:1]};
					end
					lane_pos[g] <= shift[g][0];
					lane_neg[g] <= !shift[g][0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Forwarded clock and driver enables.
	// ------------------------------------------------------------
	// Clock goes high with bit 0 of each slice, so its period frames the seven
	// bits; it is registered one cycle late exactly like the lane bits.
	always_ff @(posedge serial_bit_clk) begin
		if (lnk_clear) begin
			forwarded_clock_pos <= 1'b0;
			forwarded_clock_neg <= 1'b0;
		end else if (lnk_state == PXS_LNK_RUN) begin
			forwarded_clock_pos <= (slot < PXS_CLK_HIGH_SLOTS);
			forwarded_clock_neg <= !(slot < PXS_CLK_HIGH_SLOTS);
		end
	end

	// Drivers stay released through shutdown and turn on at the first period boundary after it.
	always_ff @(posedge serial_bit_clk) begin
		if (lnk_clear) begin
			lane_oe            <= 1'b0;
			forwarded_clock_oe <= 1'b0;
		end else if (load_now) begin
			lane_oe            <= 1'b1;
			forwarded_clock_oe <= 1'b1;
		end
	end

endmodule

//--- verif/pxs_monitor.sv
// Concurrent checks on the pins of the pixel serializer.
`timescale 1ns/1ps
module pxs_monitor
	import pxs_pkg::*;
#(
	parameter int LANES = PXS_LANES
) (
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic             serial_bit_clk,
	input wire logic             shutdown_clear_n,
	input wire logic [LANES-1:0] lane_pos,
	input wire logic [LANES-1:0] lane_neg,
	input wire logic             lane_oe,
	input wire logic             forwarded_clock_pos,
	input wire logic             forwarded_clock_neg,
	input wire logic             forwarded_clock_oe,
	input wire logic             pixel_overflow
);
	// ------------------------------------------------------------
	// Building blocks.
	// ------------------------------------------------------------
	// Six samples leave room for the two-flop synchronizer and the output flop.
	sequence s_sd_held;
		!shutdown_clear_n [*6];
	endsequence
	sequence s_high4;
		forwarded_clock_pos [*4];
	endsequence
	sequence s_low3;
		!forwarded_clock_pos [*3];
	endsequence

	// ------------------------------------------------------------
	// Properties.
	// ------------------------------------------------------------
	property p_fclk_shape;
		@(posedge serial_bit_clk) disable iff (sys_rst || !shutdown_clear_n)
		$rose(forwarded_clock_pos) |-> s_high4 ##1 s_low3 ##1 forwarded_clock_pos;
	endproperty
	a_fclk_shape: assert property (p_fclk_shape) else $error("clock shape wrong");
	property p_lane_diff;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		lane_oe |-> (lane_neg == ~lane_pos);
	endproperty
	a_lane_diff: assert property (p_lane_diff) else $error("lane pair not opposite");
	property p_fclk_diff;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		forwarded_clock_oe |-> (forwarded_clock_neg == ~forwarded_clock_pos);
	endproperty
	a_fclk_diff: assert property (p_fclk_diff) else $error("clock pair not opposite");
	property p_sd_lanes;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		s_sd_held |-> !lane_oe && (lane_pos == '0);
	endproperty
	a_sd_lanes: assert property (p_sd_lanes) else $error("lanes live in shutdown");
	property p_sd_fclk;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		s_sd_held |-> !forwarded_clock_oe && !forwarded_clock_pos;
	endproperty
	a_sd_fclk: assert property (p_sd_fclk) else $error("clock live in shutdown");
	property p_sd_ovf;
		@(posedge ref_clk) disable iff (sys_rst)
		s_sd_held |-> !pixel_overflow;
	endproperty
	a_sd_ovf: assert property (p_sd_ovf) else $error("overflow kept in shutdown");
	property p_lane_off;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		!lane_oe |-> (lane_pos == '0) && (lane_neg == '0);
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("lanes not zero while off");
	property p_fclk_off;
		@(posedge serial_bit_clk) disable iff (sys_rst)
		!forwarded_clock_oe |-> !forwarded_clock_pos && !forwarded_clock_neg;
	endproperty
	a_fclk_off: assert property (p_fclk_off) else $error("clock not zero while off");
	property p_ovf_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		pixel_overflow && shutdown_clear_n |=> pixel_overflow;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
endmodule

bind pxs_serializer pxs_monitor #(.LANES(LANES)) u_mon (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_bit_clk(serial_bit_clk),
	.shutdown_clear_n(shutdown_clear_n), .lane_pos(lane_pos), .lane_neg(lane_neg),
	.lane_oe(lane_oe), .forwarded_clock_pos(forwarded_clock_pos),
	.forwarded_clock_neg(forwarded_clock_neg), .forwarded_clock_oe(forwarded_clock_oe),
	.pixel_overflow(pixel_overflow));

//--- verif/pxs_rx_model.sv
// Display receiver model that rebuilds pixel words from the lanes.
`timescale 1ns/1ps
module pxs_rx_model
	import pxs_pkg::*;
(
	input wire logic                      clk,
	input wire logic [PXS_LANES-1:0]      lane_pos,
	input wire logic                      lane_oe,
	input wire logic                      fclk,
	output logic     [PXS_PIXEL_BITS-1:0] nz_word,
	output int                            nz_count
);
	logic [PXS_PIXEL_BITS-1:0] acc  = '0;
	logic                      prev = 1'b0;
	int                        slot = 7;

	initial nz_word = '0;
	initial nz_count = 0;

	// A clock rise marks bit 0; idle periods of zeros are not reported.
	always @(posedge clk) begin
		slot = (fclk && !prev) ? 0 : slot + 1;
		prev = fclk;
		if (lane_oe && slot < 7) begin
			for (int k = 0; k < PXS_LANES; k++) acc[7*k+slot] = lane_pos[k];
			if (slot == 6 && acc != '0) begin
				nz_word = acc;
				nz_count++;
			end
		end
	end
endmodule

//--- verif/pxs_serializer_tb_top.sv
// Self-checking bench for the pixel serializer.
`timescale 1ns/1ps
module pxs_serializer_tb_top;
	import pxs_pkg::*;
	logic        ref_clk = 1'b0;
	logic        bit_clk = 1'b0;
	logic        bit_en = 1'b1;
	logic        sys_rst = 1'b1;
	logic        input_pixel_clock = 1'b0;
	logic        capture_edge_select = 1'b1;
	logic [27:0] pixel_data = '0;
	logic        shutdown_clear_n = 1'b1;
	logic [3:0]  lane_pos;
	logic        lane_oe;
	logic        forwarded_clock_pos;
	logic        forwarded_clock_oe;
	logic        pixel_overflow;
	logic [27:0] nz_word;
	int          nz_count;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [27:0] words [4] = '{28'hFFFFFFF, 28'h0000001, 28'h8000000, 28'h1234567};

	// ------------------------------------------------------------
	// Clocks, design and receiver.
	// ------------------------------------------------------------
	always #25 ref_clk = ~ref_clk;
	// The link clock can be frozen to stall draining of the buffer.
	initial begin
		#3.3;
		forever #6 if (bit_en) bit_clk = ~bit_clk;
	end
	pxs_serializer DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_bit_clk(bit_clk),
		.input_pixel_clock(input_pixel_clock), .capture_edge_select(capture_edge_select),
		.pixel_data(pixel_data), .shutdown_clear_n(shutdown_clear_n), .lane_pos(lane_pos),
		.lane_neg(), .lane_oe(lane_oe), .forwarded_clock_pos(forwarded_clock_pos),
		.forwarded_clock_neg(), .forwarded_clock_oe(forwarded_clock_oe),
		.pixel_overflow(pixel_overflow));
	pxs_rx_model u_rx (.clk(bit_clk), .lane_pos(lane_pos), .lane_oe(lane_oe),
		.fclk(forwarded_clock_pos), .nz_word(nz_word), .nz_count(nz_count));

	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic end_sim();
		if (bad_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [27:0] exp, input logic [27:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	// The word is valid only around the selected edge, its inverse around the other.
	// A 16-cycle pixel period keeps the slow sampled pixel clock legal.
	task automatic send_pixel(input logic [27:0] w);
		pixel_data = capture_edge_select ? w : ~w;
		tick(4);
		input_pixel_clock = 1'b1;
		tick(4);
		pixel_data = capture_edge_select ? ~w : w;
		tick(4);
		input_pixel_clock = 1'b0;
		tick(4);
	endtask
	task automatic send_and_expect(input logic [27:0] w);
		int n0;
		n0 = nz_count;
		send_pixel(w);
		for (int i = 0; i < 100 && nz_count == n0; i++) tick(1);
		chk_word("received word", w, nz_word);
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	// Both edge selections, boundary words back to back.
	task automatic t_edges();
		chk_flag("lane_oe", 1'b1, lane_oe);
		for (int s = 1; s >= 0; s--) begin
			capture_edge_select = s[0];
			tick(4);
			foreach (words[i]) send_and_expect(words[i]);
		end
	endtask
	// Stall the link to fill the buffer, then shut down and recover.
	task automatic t_shutdown();
		bit_en = 1'b0;
		repeat (12) send_pixel(28'h0F0F0F0);
		chk_flag("overflow", 1'b1, pixel_overflow);
		bit_en = 1'b1;
		shutdown_clear_n = 1'b0;
		tick(20);
		chk_flag("lane_oe", 1'b0, lane_oe);
		chk_flag("clock_oe", 1'b0, forwarded_clock_oe);
		chk_word("lanes", 28'h0, {24'h0, lane_pos});
		chk_flag("overflow", 1'b0, pixel_overflow);
		shutdown_clear_n = 1'b1;
		tick(10);
		chk_flag("lane_oe", 1'b1, lane_oe);
		send_and_expect(28'hC0FFEE1);
		// With 18-bit colour the seven unused inputs are grounded by the source.
		send_and_expect(28'h77CF3DF);
		chk_word("unused slots", 28'h0000000, nz_word & 28'h8830C20);
	endtask

	// Ceiling well above the roughly 450 cycles the scenarios need.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		tick(10);
		sys_rst = 1'b0;
		tick(10);
		t_edges();
		t_shutdown();
		end_sim();
	end
endmodule
